// ---- aas_pkg.sv ----
/*
 * Shared constants of the accumulator, table-read and skip unit:
 * operation codes, sequencer states, register map, field positions,
 * reset values and ROM page limits.
 * Assumes a core clock and an AHB-Lite register bus of 32 bits.
 */
// Behaviour
// - load immediate writes nibble to accumulator
// - back-to-back loads: only first one executes
// - table read: bits 7-4 to B, 3-0 to A
// - table address is D low bits over accumulator
// - page limited to 31, 47 or 127
// - upper bits flag: ROM 9-8 into D
// - table read holds one return stack level
// - add memory to accumulator, carry unchanged
// - add memory plus carry, carry out saved
// - add immediate, skip unless overflow, carry kept
// - accumulator AND addressed word into accumulator
// - accumulator OR addressed word into accumulator
// - set carry to one only
// - clear carry to zero only
// - skip next when carry is zero
// - accumulator replaced by its complement
// - rotate carry and accumulator right by one
// - set bit j of addressed word
// - clear bit j of addressed word
// - skip next when bit j is zero
package aas_pkg;

    // Decoded operation presented by the sequencer
    typedef enum logic [3:0] {
        OP_NOP                   = 4'h0,
        OP_LOAD_IMMEDIATE        = 4'h1,
        OP_TABLE_READ            = 4'h2,
        OP_ADD_MEMORY            = 4'h3,
        OP_ADD_MEMORY_CARRY      = 4'h4,
        OP_ADD_IMMEDIATE         = 4'h5,
        OP_AND_MEMORY            = 4'h6,
        OP_OR_MEMORY             = 4'h7,
        OP_SET_CARRY             = 4'h8,
        OP_CLEAR_CARRY           = 4'h9,
        OP_CARRY_ZERO_SKIP       = 4'ha,
        OP_COMPLEMENT_ACC        = 4'hb,
        OP_ROTATE_RIGHT_CARRY    = 4'hc,
        OP_BIT_SET               = 4'hd,
        OP_BIT_CLEAR             = 4'he,
        OP_BIT_ZERO_SKIP         = 4'hf
    } aas_op_t;

    // Table-read sequencer, Gray along idle -> rom -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROM  = 2'b01
    } aas_state_t;

    // Register byte offsets
    localparam logic [7:0] OFS_ACC   = 8'h00;
    localparam logic [7:0] OFS_BREG  = 8'h04;
    localparam logic [7:0] OFS_DREG  = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;

    // Flags register fields
    localparam int FLD_CARRY   = 0;
    localparam int FLD_UPPER_TABLE_BITS_ENABLE    = 1;
    localparam int FLD_VAR_LO  = 2;
    localparam int FLD_VAR_HI  = 3;
    localparam int FLD_SKIP    = 4;
    localparam int FLD_BUSY    = 5;
    localparam int FLD_STKHOLD = 6;

    // Reset values
    localparam logic [3:0] RST_NIBBLE  = 4'h0;
    localparam logic [2:0] RST_DREG    = 3'h0;
    localparam logic [1:0] RST_VARIANT = 2'h0;

    // Largest page per fitted ROM size
    localparam logic [6:0] PAGE_MAX_SMALL = 7'h1f;
    localparam logic [6:0] PAGE_MAX_MID   = 7'h2f;
    localparam logic [6:0] PAGE_MAX_LARGE = 7'h7f;

    // Widths
    localparam int NIB_W      = 4;
    localparam int ROM_W      = 10;
    localparam int ROM_ADDR_W = 14;

endpackage

// ---- aas_alu.sv ----
/*
 * Combinational operation unit: computes next accumulator, carry,
 * addressed data word and skip condition for one decoded operation.
 * Assumes the caller gates every write enable with its execute term.
 */
`timescale 1ns/100ps
module aas_alu
    import aas_pkg::*;
(
    // Operation
    input  aas_op_t         op,
    input  wire logic [3:0] imm,
    // Current state
    input  wire logic [3:0] acc,
    input  wire logic       carry,
    input  wire logic [3:0] mem,
    // Results
    output logic [3:0]      acc_next,
    output logic            acc_we,
    output logic            carry_next,
    output logic            carry_we,
    output logic [3:0]      mem_next,
    output logic            mem_we,
    output logic            skip
);

    logic [4:0] sum_mem;
    logic [4:0] sum_memc;
    logic [4:0] sum_imm;

    // Five-bit sums so bit 4 is the carry out of bit 3
    assign sum_mem  = {1'b0, acc} + {1'b0, mem};
    assign sum_memc = {1'b0, acc} + {1'b0, mem} + {4'h0, carry};
    assign sum_imm  = {1'b0, acc} + {1'b0, imm};

    // Operation decode
    always_comb
    begin
        acc_next   = acc;
        acc_we     = 1'b0;
        carry_next = carry;
        carry_we   = 1'b0;
        mem_next   = mem;
        mem_we     = 1'b0;
        skip       = 1'b0;
        case (op)
            OP_LOAD_IMMEDIATE:
            begin
                acc_next = imm;
                acc_we   = 1'b1;
            end
            OP_ADD_MEMORY:
            begin
                acc_next = sum_mem[3:0];
                acc_we   = 1'b1;
            end
            OP_ADD_MEMORY_CARRY:
            begin
                acc_next   = sum_memc[3:0];
                acc_we     = 1'b1;
                carry_next = sum_memc[4];
                carry_we   = 1'b1;
            end
            OP_ADD_IMMEDIATE:
            begin
                acc_next = sum_imm[3:0];
                acc_we   = 1'b1;
                skip     = ~sum_imm[4];
            end
            OP_AND_MEMORY:
            begin
                acc_next = acc & mem;
                acc_we   = 1'b1;
            end
            OP_OR_MEMORY:
            begin
                acc_next = acc | mem;
                acc_we   = 1'b1;
            end
            OP_SET_CARRY:
            begin
                carry_next = 1'b1;
                carry_we   = 1'b1;
            end
            OP_CLEAR_CARRY:
            begin
                carry_next = 1'b0;
                carry_we   = 1'b1;
            end
            OP_CARRY_ZERO_SKIP:
            begin
                skip = ~carry;
            end
            OP_COMPLEMENT_ACC:
            begin
                acc_next = ~acc;
                acc_we   = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY:
            begin
                acc_next   = {carry, acc[3:1]};
                acc_we     = 1'b1;
                carry_next = acc[0];
                carry_we   = 1'b1;
            end
            OP_BIT_SET:
            begin
                mem_next         = mem;
                mem_next[imm[1:0]] = 1'b1;
                mem_we           = 1'b1;
            end
            OP_BIT_CLEAR:
            begin
                mem_next         = mem;
                mem_next[imm[1:0]] = 1'b0;
                mem_we           = 1'b1;
            end
            OP_BIT_ZERO_SKIP:
            begin
                skip = ~mem[imm[1:0]];
            end
            default:
            begin
                skip = 1'b0;
            end
        endcase
    end

endmodule

// ---- aas_core.sv ----
/*
 * Accumulator, table-read and skip unit of a 4-bit core, with its
 * architectural registers visible over an AHB-Lite slave.
 * Assumes the sequencer holds off new instructions while busy is high,
 * the data RAM presents the addressed word combinationally, and the
 * program ROM answers a table read with a one-cycle valid pulse.
 */
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module aas_core
    import aas_pkg::*;
(
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // Instruction from the sequencer
    input  wire logic                  instr_valid,
    input  aas_op_t                    instr_op,
    input  wire logic [3:0]            instr_imm,
    input  wire logic [6:0]            instr_page,
    output logic                       busy,
    output logic                       skip_pending,
    // Data memory word at the data pointer
    input  wire logic [3:0]            addressed_data_word,
    output logic [3:0]                 mem_wdata,
    output logic                       mem_we,
    // Program ROM table port
    output logic                       rom_req,
    output logic [ROM_ADDR_W-1:0]      rom_addr,
    input  wire logic                  rom_rvalid,
    input  wire logic [ROM_W-1:0]      rom_rdata,
    // Return stack occupancy
    output logic                       return_stack_hold
);

    // Architectural state
    logic [3:0]       acc_q;
    logic [3:0]       breg_q;
    logic [2:0]       dreg_q;
    logic             carry_flag_q;
    logic             upper_table_bits_enable_q;
    logic [1:0]       variant_q;
    logic             skip_q;
    logic             last_load_q;
    aas_state_t       state_q;
    logic             rom_req_q;
    logic [ROM_ADDR_W-1:0] rom_addr_q;

    // Bus pipeline
    logic             bus_wr_q;
    logic [7:0]       bus_addr_q;
    logic [31:0]      hrdata_q;
    logic             addr_phase;
    logic             bus_wr_acc;
    logic             bus_wr_breg;
    logic             bus_wr_dreg;
    logic             bus_wr_flags;

    // Execution terms
    logic             accept;
    logic             exec;
    logic             tbl_start;
    logic             tbl_done;
    logic [6:0]       page_max;
    logic [6:0]       page_eff;

    // ALU results
    logic [3:0]       alu_acc;
    logic             alu_acc_we;
    logic             alu_carry;
    logic             alu_carry_we;
    logic [3:0]       alu_mem;
    logic             alu_mem_we;
    logic             alu_skip;

    aas_alu u_alu (
        .op         (instr_op),
        .imm        (instr_imm),
        .acc        (acc_q),
        .carry      (carry_flag_q),
        .mem        (addressed_data_word),
        .acc_next   (alu_acc),
        .acc_we     (alu_acc_we),
        .carry_next (alu_carry),
        .carry_we   (alu_carry_we),
        .mem_next   (alu_mem),
        .mem_we     (alu_mem_we),
        .skip       (alu_skip)
    );

    // An instruction is taken only while no table read is in flight
    assign accept = instr_valid && (state_q == ST_IDLE);

    // Skipped slot still consumes the fetch but updates nothing
    assign exec = accept && !skip_q
                  && !((instr_op == OP_LOAD_IMMEDIATE)
                       && last_load_q);

    assign tbl_start = exec && (instr_op == OP_TABLE_READ);
    assign tbl_done  = (state_q == ST_ROM) && rom_rvalid;

    // Largest page of the fitted ROM
    always_comb
    begin
        if (variant_q == 2'h0)
        begin
            page_max = PAGE_MAX_SMALL;
        end
        else if (variant_q == 2'h1)
        begin
            page_max = PAGE_MAX_MID;
        end
        else
        begin
            page_max = PAGE_MAX_LARGE;
        end
    end

    // Out-of-range pages clamp rather than alias into another page
    assign page_eff = (instr_page > page_max) ? page_max
                                              : instr_page;

    // Table-read sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (tbl_start)
                    begin
                        state_q <= ST_ROM;
                    end
                end
                ST_ROM:
                begin
                    if (rom_rvalid)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ROM request pulse and address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rom_req_q  <= 1'b0;
            rom_addr_q <= '0;
        end
        else
        begin
            rom_req_q <= tbl_start;
            if (tbl_start)
            begin
                rom_addr_q <= {page_eff, dreg_q, acc_q};
            end
        end
    end

    // Skip and load-run tracking; a fetched slot consumes a pending skip
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            skip_q      <= 1'b0;
            last_load_q <= 1'b0;
        end
        else if (accept)
        begin
            skip_q      <= exec && alu_skip;
            last_load_q <= (instr_op == OP_LOAD_IMMEDIATE);
        end
    end

    // Accumulator: execution wins over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_q <= RST_NIBBLE;
        end
        else if (exec && alu_acc_we)
        begin
            acc_q <= alu_acc;
        end
        else if (tbl_done)
        begin
            acc_q <= rom_rdata[3:0];
        end
        else if (bus_wr_acc)
        begin
            acc_q <= hwdata[3:0];
        end
    end

    // Register B
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            breg_q <= RST_NIBBLE;
        end
        else if (tbl_done)
        begin
            breg_q <= rom_rdata[7:4];
        end
        else if (bus_wr_breg)
        begin
            breg_q <= hwdata[3:0];
        end
    end

    // Register D
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dreg_q <= RST_DREG;
        end
        else if (tbl_done && upper_table_bits_enable_q)
        begin
            dreg_q <= {1'b0, rom_rdata[9:8]};
        end
        else if (bus_wr_dreg)
        begin
            dreg_q <= hwdata[2:0];
        end
    end

    // Carry, flag enable and ROM size variant
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            carry_flag_q              <= 1'b0;
            upper_table_bits_enable_q <= 1'b0;
            variant_q                 <= RST_VARIANT;
        end
        else
        begin
            if (exec && alu_carry_we)
            begin
                carry_flag_q <= alu_carry;
            end
            else if (bus_wr_flags)
            begin
                carry_flag_q <= hwdata[FLD_CARRY];
            end
            if (bus_wr_flags)
            begin
                upper_table_bits_enable_q <= hwdata[FLD_UPPER_TABLE_BITS_ENABLE];
                variant_q <= hwdata[FLD_VAR_HI:FLD_VAR_LO];
            end
        end
    end

    // Data memory write strobe, only for executed bit operations
    assign mem_we    = exec && alu_mem_we;
    assign mem_wdata = alu_mem;

    // Status to the sequencer and ROM
    assign busy              = (state_q != ST_IDLE);
    assign return_stack_hold = (state_q != ST_IDLE);
    assign skip_pending      = skip_q;
    assign rom_req           = rom_req_q;
    assign rom_addr          = rom_addr_q;

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign addr_phase = hsel && htrans[1] && hready;

    // Address phase capture; read data prepared for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_wr_q   <= 1'b0;
            bus_addr_q <= 8'h00;
            hrdata_q   <= 32'h0000_0000;
        end
        else
        begin
            bus_wr_q   <= addr_phase && hwrite;
            bus_addr_q <= haddr[7:0];
            hrdata_q   <= 32'h0000_0000;
            if (addr_phase && !hwrite)
            begin
                if (haddr[7:0] == OFS_ACC)
                begin
                    hrdata_q[3:0] <= acc_q;
                end
                else if (haddr[7:0] == OFS_BREG)
                begin
                    hrdata_q[3:0] <= breg_q;
                end
                else if (haddr[7:0] == OFS_DREG)
                begin
                    hrdata_q[2:0] <= dreg_q;
                end
                else if (haddr[7:0] == OFS_FLAGS)
                begin
                    hrdata_q[FLD_CARRY]          <= carry_flag_q;
                    hrdata_q[FLD_UPPER_TABLE_BITS_ENABLE]           <= upper_table_bits_enable_q;
                    hrdata_q[FLD_VAR_HI:FLD_VAR_LO] <= variant_q;
                    hrdata_q[FLD_SKIP]           <= skip_q;
                    hrdata_q[FLD_BUSY]           <= busy;
                    hrdata_q[FLD_STKHOLD]        <= return_stack_hold;
                end
            end
        end
    end

    // Data phase write decode; unmapped writes fall through unused
    assign bus_wr_acc   = bus_wr_q && (bus_addr_q == OFS_ACC);
    assign bus_wr_breg  = bus_wr_q && (bus_addr_q == OFS_BREG);
    assign bus_wr_dreg  = bus_wr_q && (bus_addr_q == OFS_DREG);
    assign bus_wr_flags = bus_wr_q && (bus_addr_q == OFS_FLAGS);

endmodule

// ---- aas_core_asserts.sv ----
/*
 * Port checker for aas_core: table-read handshake, RAM writes, skips.
 * Bound to every aas_core instance; sees its ports only.
 */
`timescale 1ns/100ps
module aas_core_chk
    import aas_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Bus answer
    input  wire logic       hreadyout,
    input  wire logic       hresp,
    // Instruction port
    input  wire logic       instr_valid,
    input  aas_op_t         instr_op,
    input  wire logic [3:0] instr_imm,
    input  wire logic       busy,
    input  wire logic       skip_pending,
    // RAM and ROM sides
    input  wire logic [3:0] addressed_data_word,
    input  wire logic [3:0] mem_wdata,
    input  wire logic       mem_we,
    input  wire logic       rom_req,
    input  wire logic       rom_rvalid,
    input  wire logic       return_stack_hold
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Slot that really executes, and the bit it selects
    logic       run;
    logic [3:0] bit_j;
    logic       bit_hit;
    assign run     = instr_valid && !busy && !skip_pending;
    assign bit_j   = 4'h1 << instr_imm[1:0];
    assign bit_hit = |(addressed_data_word & bit_j);

    sequence s_tbl_go;
        run && instr_op == OP_TABLE_READ;
    endsequence
    sequence s_tbl_issue;
        rom_req && busy && return_stack_hold;
    endsequence

    AST_TBL_ISSUE: assert property (s_tbl_go |=> s_tbl_issue)
        else $error("table read did not issue");
    AST_STACK_HOLD: assert property (return_stack_hold == busy)
        else $error("stack hold differs from busy");
    AST_TBL_DONE: assert property (busy && rom_rvalid |=> !busy)
        else $error("busy outlived the ROM answer");
    AST_REQ_PULSE: assert property (rom_req |=> !rom_req)
        else $error("ROM request longer than one cycle");
    AST_BIT_SET: assert property (run && instr_op == OP_BIT_SET
        |-> mem_we && mem_wdata == (addressed_data_word | bit_j))
        else $error("bad bit set write");
    AST_BIT_CLR: assert property (run && instr_op == OP_BIT_CLEAR
        |-> mem_we && mem_wdata == (addressed_data_word & ~bit_j))
        else $error("bad bit clear write");
    AST_BIT_SKIP: assert property (run && instr_op == OP_BIT_ZERO_SKIP
        |=> skip_pending == !$past(bit_hit))
        else $error("bit test skip wrong");
    AST_SKIP_QUIET: assert property (instr_valid && !busy && skip_pending
        |-> !mem_we ##1 !skip_pending)
        else $error("skipped slot had an effect");
    AST_IDLE_NO_WE: assert property (!(instr_valid && !busy) |-> !mem_we)
        else $error("RAM write without instruction");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and OKAY");
endmodule

bind aas_core aas_core_chk u_chk (
    .hclk, .hresetn, .hreadyout, .hresp, .instr_valid, .instr_op,
    .instr_imm, .busy, .skip_pending, .addressed_data_word, .mem_wdata,
    .mem_we, .rom_req, .rom_rvalid, .return_stack_hold
);

// ---- aas_far_model.sv ----
/*
 * Far-side model: program ROM table port and the data RAM word at
 * the data pointer. Assumes the bench presets the RAM word.
 */
`timescale 1ns/100ps
module aas_far_model
    import aas_pkg::*;
(
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ROM table port
    input  wire logic                  rom_req,
    input  wire logic [ROM_ADDR_W-1:0] rom_addr,
    input  wire logic [2:0]            rom_lat,
    output logic                       rom_rvalid,
    output logic [ROM_W-1:0]           rom_rdata,
    // Data RAM word
    input  wire logic                  mem_we,
    input  wire logic [3:0]            mem_wdata,
    input  wire logic                  ram_load,
    input  wire logic [3:0]            ram_load_val,
    output logic [3:0]                 addressed_data_word
);
    logic [2:0]            cnt_q;
    logic [ROM_ADDR_W-1:0] addr_q;

    // Answer rom_lat cycles after the request; data churns otherwise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q      <= 3'h0;
            addr_q     <= '0;
            rom_rvalid <= 1'b0;
            rom_rdata  <= '0;
        end
        else
        begin
            rom_rvalid <= 1'b0;
            rom_rdata  <= ~rom_rdata;
            if (rom_req)
            begin
                addr_q <= rom_addr;
                cnt_q  <= rom_lat;
            end
            else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
            if (!rom_req && cnt_q == 3'h1)
            begin
                rom_rvalid <= 1'b1;
                rom_rdata  <= {addr_q[1:0], addr_q[7:0] ^ 8'h96};
            end
        end
    end

    // RAM word: bench preset wins over a core write
    always_ff @(posedge hclk)
    begin
        if (ram_load)
            addressed_data_word <= ram_load_val;
        else if (mem_we)
            addressed_data_word <= mem_wdata;
    end
endmodule

// ---- tb.sv ----
/*
 * Self-checking bench for aas_core: AHB-Lite tasks, an instruction
 * task and a table of single-instruction cases.
 * Assumes the far-side model aas_far_model and the bound checker.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb
    import aas_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, rom_lat = 3'h1, ed;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        instr_valid = 1'b0, ram_load = 1'b1;
    aas_op_t     instr_op = OP_NOP;
    logic [3:0]  instr_imm = 4'h0, ram_load_val = 4'h0, ea;
    logic [6:0]  instr_page = 7'h0;
    logic        hreadyout, hresp, busy, skip_pending, mem_we;
    logic        rom_req, rom_rvalid, return_stack_hold;
    logic [3:0]  addressed_data_word, mem_wdata;
    logic [13:0] rom_addr, ta;
    logic [9:0]  rom_rdata, w;
    logic [35:0] v;
    int          err_total = 0, n_tests = 0;
    // Cases: op imm acc carry mem | acc carry skip mem expected
    localparam int NV = 22;
    logic [35:0] vec [NV] = '{
        36'h1_5_0_0_0_5_0_0_0, 36'h3_0_c_1_6_2_1_0_6,
        36'h4_0_c_1_6_3_1_0_6, 36'h4_0_2_0_3_5_0_0_3,
        36'h4_0_9_1_6_0_1_0_6, 36'h5_1_f_1_0_0_1_0_0,
        36'h5_2_f_0_0_1_0_0_0, 36'h5_2_1_1_0_3_1_1_0,
        36'h6_0_c_0_a_8_0_0_a, 36'h7_0_c_0_3_f_0_0_3,
        36'h8_0_4_0_0_4_1_0_0, 36'h9_0_4_1_0_4_0_0_0,
        36'ha_0_4_0_0_4_0_1_0, 36'ha_0_4_1_0_4_1_0_0,
        36'hb_0_5_0_0_a_0_0_0, 36'hc_0_5_0_0_2_1_0_0,
        36'hc_0_4_1_0_a_0_0_0, 36'hd_2_4_0_1_4_0_0_5,
        36'hd_3_4_0_0_4_0_0_8, 36'he_0_4_0_f_4_0_0_e,
        36'hf_1_4_0_d_4_0_1_d, 36'hf_2_4_0_4_4_0_0_4
    };
    logic [6:0]  pin [3] = '{7'h20, 7'h30, 7'h7f};
    logic [6:0]  pmax [3] = '{7'h1f, 7'h2f, 7'h7f};

    aas_core DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instr_valid,
        .instr_op, .instr_imm, .instr_page, .busy, .skip_pending,
        .addressed_data_word, .mem_wdata, .mem_we, .rom_req, .rom_addr,
        .rom_rvalid, .rom_rdata, .return_stack_hold
    );
    aas_far_model u_far (
        .hclk, .hresetn, .rom_req, .rom_addr, .rom_lat, .rom_rvalid,
        .rom_rdata, .mem_we, .mem_wdata, .ram_load, .ram_load_val,
        .addressed_data_word
    );

    // Free-running core clock, 4 ns period
    always #2 hclk = ~hclk;

    task automatic print_verdict(input bit hang);
        if (hang) err_total++;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One phase: wait for hready under a bound
    task automatic bus_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) print_verdict(1'b1);
    endtask

    task automatic bus_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        bus_wait();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
        rd = hrdata; // Still the data-phase value at this edge
    endtask

    // Last slot of a run drops valid just after its edge
    task automatic exec(input aas_op_t op, input logic [3:0] imm,
                        input bit last);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_imm   <= imm;
        @(posedge hclk);
        if (last)
        begin
            instr_valid <= 1'b0;
        end
    endtask

    // Busy seen at an edge is the level of the cycle just ended
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (busy !== 1'b0 && n < 20);
        if (busy !== 1'b0) print_verdict(1'b1);
    endtask

    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn  <= 1'b1;
        ram_load <= 1'b0;
        bus_xfer(1'b1, 8'h10, 32'hf);
        for (int r = 0; r < 5; r++)
        begin
            bus_xfer(1'b0, 8'(4 * r), 32'h0);
            `CHK(rd, 32'h0)
        end
        exec(OP_LOAD_IMMEDIATE, 4'h5, 1'b0);
        exec(OP_LOAD_IMMEDIATE, 4'h9, 1'b0);
        exec(OP_LOAD_IMMEDIATE, 4'h3, 1'b0);
        exec(OP_NOP, 4'h0, 1'b1);
        bus_xfer(1'b0, OFS_ACC, 32'h0);
        `CHK(rd, 32'h5)
        for (int i = 0; i < NV; i++)
        begin
            v = vec[i];
            ram_load     <= 1'b1;
            ram_load_val <= v[19:16];
            bus_xfer(1'b1, OFS_ACC, {28'h0, v[27:24]});
            ram_load     <= 1'b0;
            bus_xfer(1'b1, OFS_FLAGS, {31'h0, v[20]});
            exec(aas_op_t'(v[35:32]), v[31:28], 1'b1);
            bus_xfer(1'b0, OFS_ACC, 32'h0);
            `CHK(rd, {28'h0, v[15:12]})
            bus_xfer(1'b0, OFS_FLAGS, 32'h0);
            `CHK(rd[0], v[8])
            `CHK(rd[4], v[4])
            `CHK(addressed_data_word, v[3:0])
            exec(OP_COMPLEMENT_ACC, 4'h0, 1'b1);
            bus_xfer(1'b0, OFS_ACC, 32'h0);
            `CHK(rd[3:0], v[4] ? v[15:12] : ~v[15:12])
        end
        // Table reads: every size variant, slow and prompt ROM
        bus_xfer(1'b1, OFS_ACC, 32'ha);
        bus_xfer(1'b1, OFS_DREG, 32'h5);
        ea = 4'ha;
        ed = 3'h5;
        for (int k = 0; k < 3; k++)
        begin
            rom_lat    <= 3'(3 * k + 1);
            instr_page <= pin[k];
            bus_xfer(1'b1, OFS_FLAGS, {28'h0, 2'(k), ~k[0], 1'b0});
            exec(OP_TABLE_READ, 4'h0, 1'b1);
            wait_idle();
            ta = {pmax[k], ed, ea};
            w  = {ta[1:0], ta[7:0] ^ 8'h96};
            `CHK(rom_addr, ta)
            bus_xfer(1'b0, OFS_BREG, 32'h0);
            `CHK(rd, {28'h0, w[7:4]})
            bus_xfer(1'b0, OFS_ACC, 32'h0);
            `CHK(rd, {28'h0, w[3:0]})
            if (!k[0]) ed = {1'b0, w[9:8]};
            bus_xfer(1'b0, OFS_DREG, 32'h0);
            `CHK(rd, {29'h0, ed})
            ea = w[3:0];
        end
        print_verdict(1'b0);
    end
endmodule
